// ### ddchb_params.svh
// ddchb_params.svh: register indices, field positions, reset values and
// filter geometry for the down-converter half-band back end.
// assumes: included by its bare name; definitions only.
`ifndef DDCHB_PARAMS_SVH
`define DDCHB_PARAMS_SVH

// register indices; byte address is four times the index
`define DDCHB_IDX_CHIP_MODE 10'h200
`define DDCHB_IDX_CHIP_DEC 10'h201
`define DDCHB_IDX_STATUS 10'h202
`define DDCHB_IDX_CH0_CTRL 10'h310
`define DDCHB_IDX_CH0_ISEL 10'h311
`define DDCHB_IDX_CH0_FTW_LO 10'h314
`define DDCHB_IDX_CH0_FTW_HI 10'h315
`define DDCHB_IDX_CH0_POW_LO 10'h320
`define DDCHB_IDX_CH0_POW_HI 10'h321
`define DDCHB_IDX_CH1_CTRL 10'h330
`define DDCHB_IDX_CH1_ISEL 10'h331
`define DDCHB_IDX_CH1_FTW_LO 10'h334
`define DDCHB_IDX_CH1_FTW_HI 10'h335
`define DDCHB_IDX_CH1_POW_LO 10'h340
`define DDCHB_IDX_CH1_POW_HI 10'h341

// storage slots
`define DDCHB_NUM_SLOTS 4'hE
`define DDCHB_SLOT_STATUS 4'hE
`define DDCHB_SLOT_NONE 4'hF
`define DDCHB_REG_RST 8'h00

// chip mode fields and values
`define DDCHB_MODE_QIGN_BIT 5
`define DDCHB_MODE_NONE 2'h0
`define DDCHB_MODE_TWO 2'h2

// channel control fields
`define DDCHB_CTRL_CMIX_BIT 7
`define DDCHB_CTRL_GAIN_BIT 6
`define DDCHB_CTRL_REAL_BIT 3
`define DDCHB_FSEL_FINAL 2'h3
`define DDCHB_FSEL_THIRD 2'h0
`define DDCHB_FSEL_SECOND 2'h1
`define DDCHB_FSEL_FIRST 2'h2

// input select fields: set bit picks converter channel B
`define DDCHB_ISEL_I_BIT 0
`define DDCHB_ISEL_Q_BIT 2

// filter geometry
`define DDCHB_TAPS_SECOND 11
`define DDCHB_TAPS_THIRD 19
`define DDCHB_TAPS_FINAL 55
`define DDCHB_SHIFT_SECOND 17
`define DDCHB_SHIFT_THIRD 18
`define DDCHB_SHIFT_FINAL 20

`endif

// ### ddchb_pkg.sv
// ddchb_pkg.sv: types shared by the down-converter half-band back end.
// assumes: nothing beyond a SystemVerilog compiler.
package ddchb_pkg;

   typedef logic signed [15:0] ddchb_sample_t;
   typedef logic signed [47:0] ddchb_acc_t;
   typedef logic signed [21:0] ddchb_coef_t;

   // stage order along the chain
   typedef enum logic [2:0] {
      DDCHB_ST_SECOND = 3'h1,
      DDCHB_ST_THIRD = 3'h2,
      DDCHB_ST_FINAL = 3'h4
   } ddchb_stage_e;

   typedef struct packed {
      logic [13:0][7:0] regs;
      logic [31:0] prdata;
      ddchb_sample_t [1:0][1:0][2:0][54:0] taps;
      logic [1:0][2:0] ph;
      logic [1:0][2:0] sv;
      ddchb_sample_t [1:0][2:0][1:0] so;
      logic [1:0][1:0] c2r;
      logic [1:0] ov;
      ddchb_sample_t [1:0][1:0] od;
      logic rd_ok;
   } ddchb_state_s;

endpackage

// ### ddchb_back_end.sv
// ddchb_back_end.sv: two down-converter channel back ends (input routing,
// second/third/final half-band decimators, gain, complex-to-real) with an
// APB register file.
// assumes: converter samples arrive synchronous to pclk with in_valid;
// oscillator and mixer live upstream, output formatting downstream.
`timescale 1ns/10ps
`default_nettype none
`include "ddchb_params.svh"

// Operation
// - second stage taps 859, 0, -6661, symmetric, 18-bit fixed
// - second stage runs only complex dec 8/16 or real dec 4/8
// - third stage is 19-bit half-band, one output per two inputs
// - third stage runs only complex dec 4/8/16 or real 2/4/8
// - third stage taps 161..80160 mirrored around centre 131072
// - final stage is a 21-bit symmetric half-band
// - final stage is always in the path, never bypassed
// - final stage has 55 taps, odd ones zero except centre 524288
// - each channel has its own 0 dB or 6 dB gain
// - complex-to-real keeps final stage at full rate, no decimation
// - complex-to-real mixes up by fs/4 and drops quadrature
// - mode 0x01 is one channel I/Q; decimation 0x01 means two
// - control 0x83 is complex mixer, 0 dB, complex, final only
// - input select 0x04 A to I, B to Q; 0x00 all A; 0x05 all B
// - mode 0x02 is two channels I/Q; decimation 0x02 means four
// - control 0x80 is complex, 0 dB, third and final stages
// - mode 0x22 is two channels with quadrature ignored
module ddchb_back_end
   import ddchb_pkg::*;
#(
   // missing second-stage taps; defaults keep unity gain at dc
   parameter ddchb_coef_t SECOND_C5 = 22'sd38570,
   parameter ddchb_coef_t SECOND_C6 = 22'sd65536
) (
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter samples
   input wire logic in_valid,
   input wire logic [15:0] adc_a,
   input wire logic [15:0] adc_b,
   // channel 0 output
   output logic out0_valid,
   output logic [15:0] out0_i,
   output logic [15:0] out0_q,
   // channel 1 output
   output logic out1_valid,
   output logic [15:0] out1_i,
   output logic [15:0] out1_q
);

   ddchb_state_s st_q;
   ddchb_state_s st_d;
   logic [3:0] bus_slot;

   function automatic logic [3:0] slot_of(input logic [11:0] a);
      logic [9:0] idx;
      idx = a[11:2];
      if (a[1:0] != 2'h0) begin
         return `DDCHB_SLOT_NONE;
      end else if (idx == `DDCHB_IDX_CHIP_MODE) begin
         return 4'h0;
      end else if (idx == `DDCHB_IDX_CHIP_DEC) begin
         return 4'h1;
      end else if (idx == `DDCHB_IDX_CH0_CTRL) begin
         return 4'h2;
      end else if (idx == `DDCHB_IDX_CH0_ISEL) begin
         return 4'h3;
      end else if (idx == `DDCHB_IDX_CH0_FTW_LO) begin
         return 4'h4;
      end else if (idx == `DDCHB_IDX_CH0_FTW_HI) begin
         return 4'h5;
      end else if (idx == `DDCHB_IDX_CH0_POW_LO) begin
         return 4'h6;
      end else if (idx == `DDCHB_IDX_CH0_POW_HI) begin
         return 4'h7;
      end else if (idx == `DDCHB_IDX_CH1_CTRL) begin
         return 4'h8;
      end else if (idx == `DDCHB_IDX_CH1_ISEL) begin
         return 4'h9;
      end else if (idx == `DDCHB_IDX_CH1_FTW_LO) begin
         return 4'hA;
      end else if (idx == `DDCHB_IDX_CH1_FTW_HI) begin
         return 4'hB;
      end else if (idx == `DDCHB_IDX_CH1_POW_LO) begin
         return 4'hC;
      end else if (idx == `DDCHB_IDX_CH1_POW_HI) begin
         return 4'hD;
      end else if (idx == `DDCHB_IDX_STATUS) begin
         return `DDCHB_SLOT_STATUS;
      end else begin
         return `DDCHB_SLOT_NONE;
      end
   endfunction

   // tap count and output scaling per stage
   function automatic int ntaps(input int s);
      case (s)
         0: return `DDCHB_TAPS_SECOND;
         1: return `DDCHB_TAPS_THIRD;
         default: return `DDCHB_TAPS_FINAL;
      endcase
   endfunction

   function automatic int nshift(input int s);
      case (s)
         0: return `DDCHB_SHIFT_SECOND;
         1: return `DDCHB_SHIFT_THIRD;
         default: return `DDCHB_SHIFT_FINAL;
      endcase
   endfunction

   // symmetric coefficient lookup, m counts from the outer tap inward
   function automatic ddchb_coef_t coef(input int s, input int k);
      int m;
      m = (k < ntaps(s) - 1 - k) ? k : ntaps(s) - 1 - k;
      if (s == 0) begin
         case (m)
            0: return 22'sd859;
            2: return -22'sd6661;
            4: return SECOND_C5;
            5: return SECOND_C6;
            default: return 22'sd0;
         endcase
      end else if (s == 1) begin
         case (m)
            0: return 22'sd161;
            2: return -22'sd1328;
            4: return 22'sd5814;
            6: return -22'sd19272;
            8: return 22'sd80160;
            9: return 22'sd131072;
            default: return 22'sd0;
         endcase
      end else begin
         case (m)
            0: return -22'sd24;
            2: return 22'sd102;
            4: return -22'sd302;
            6: return 22'sd730;
            8: return -22'sd1544;
            10: return 22'sd2964;
            12: return -22'sd5284;
            14: return 22'sd8903;
            16: return -22'sd14383;
            18: return 22'sd22640;
            20: return -22'sd35476;
            22: return 22'sd57468;
            24: return -22'sd105442;
            26: return 22'sd331792;
            27: return 22'sd524288;
            default: return 22'sd0;
         endcase
      end
   endfunction

   // full-precision sum; 48 bits covers 55 taps of 16x22 products
   function automatic ddchb_acc_t mac(input int s, input ddchb_sample_t [54:0] w);
      ddchb_acc_t acc;
      ddchb_acc_t a;
      ddchb_acc_t b;
      acc = '0;
      for (int k = 0; k < 55; k++) begin
         a = coef(s, k);
         b = w[k];
         if (k < ntaps(s)) begin
            acc = acc + a * b;
         end
      end
      return acc;
   endfunction

   function automatic ddchb_sample_t sat(input ddchb_acc_t v);
      if (v > 48'sh7FFF) begin
         return 16'sh7FFF;
      end else if (v < -48'sh8000) begin
         return -16'sh8000;
      end else begin
         return v[15:0];
      end
   endfunction

   // read word for a slot; status is built live, holes read as zero
   function automatic logic [31:0] rd_word(input ddchb_state_s q, input logic [3:0] slot,
         input logic [1:0] on);
      logic [31:0] r;
      r = 32'h00000000;
      if (slot < `DDCHB_NUM_SLOTS) begin
         r = {24'h000000, q.regs[slot]};
      end else if (slot == `DDCHB_SLOT_STATUS) begin
         r = {24'h000000, q.c2r[1], q.c2r[0], 2'h0, on};
      end else begin
         r = 32'h00000000;
      end
      return r;
   endfunction

   // which stages a filter select switches in; the final stage never drops out
   function automatic logic stage_on(input logic [1:0] fs, input int s);
      logic on;
      on = 1'b0;
      if (s == 0) begin
         on = fs == `DDCHB_FSEL_SECOND || fs == `DDCHB_FSEL_FIRST;
      end else if (s == 1) begin
         on = fs != `DDCHB_FSEL_FINAL;
      end else begin
         on = 1'b1;
      end
      return on;
   endfunction

   // fs/4 rotation I, -Q, -I, Q; only the real part survives
   function automatic ddchb_sample_t rot(input logic [1:0] p, input ddchb_sample_t [1:0] d);
      ddchb_acc_t r;
      r = '0;
      case (p)
         2'h0: r = d[0];
         2'h1: r = -48'(d[1]);
         2'h2: r = -48'(d[0]);
         default: r = d[1];
      endcase
      return sat(r);
   endfunction

   // 6 dB is a saturating doubling, widened first so it cannot wrap
   function automatic ddchb_sample_t dbl(input ddchb_sample_t d);
      ddchb_acc_t r;
      r = d;
      return sat(r <<< 1);
   endfunction

   assign bus_slot = slot_of(paddr);

   always_comb begin
      logic [7:0] ctrl;
      logic [7:0] isel;
      logic [1:0] fsel;
      logic [1:0] en;
      logic v;
      logic act;
      logic fire;
      logic nodec;
      ddchb_sample_t [1:0] x;
      ddchb_sample_t [54:0] w;
      ddchb_acc_t t;
      ctrl = '0;
      isel = '0;
      fsel = '0;
      v = 1'b0;
      act = 1'b0;
      fire = 1'b0;
      nodec = 1'b0;
      x = '0;
      w = '0;
      t = '0;
      en = '0;
      st_d = st_q;
      // mode 1 runs channel 0 only, mode 2 runs both
      en[0] = st_q.regs[0][1:0] != `DDCHB_MODE_NONE;
      en[1] = st_q.regs[0][1:0] == `DDCHB_MODE_TWO;

      // read data is captured in the setup phase so it leaves a flip-flop;
      // a setup frozen by ce loads in the access phase instead, and
      // pready waits for that load so stale data is never taken
      if (psel && !pwrite && (!penable || !st_q.rd_ok)) begin
         st_d.prdata = rd_word(st_q, bus_slot, en);
         st_d.rd_ok = 1'b1;
      end
      // armed flag drops once the read completes or the bus idles
      if (!psel || (penable && pready)) begin
         st_d.rd_ok = 1'b0;
      end
      // software writes every slot except status; tuning and phase words are only held, mixer is upstream
      if (psel && penable && pwrite && bus_slot < `DDCHB_NUM_SLOTS) begin
         st_d.regs[bus_slot] = pwdata[7:0];
      end

      for (int c = 0; c < 2; c++) begin
         ctrl = st_q.regs[2 + 6 * c];
         isel = st_q.regs[3 + 6 * c];
         fsel = ctrl[1:0];
         v = in_valid && en[c];
         x[0] = isel[`DDCHB_ISEL_I_BIT] ? adc_b : adc_a;
         x[1] = isel[`DDCHB_ISEL_Q_BIT] ? adc_b : adc_a;
         for (int s = 0; s < 3; s++) begin
            st_d.sv[c][s] = 1'b0;
            act = stage_on(fsel, s);
            nodec = s == 2 && ctrl[`DDCHB_CTRL_REAL_BIT];
            if (act) begin
               if (v) begin
                  // second of each pair fires, every input when nodec; phase holds while idle
                  fire = st_q.ph[c][s] || nodec;
                  st_d.ph[c][s] = ~st_q.ph[c][s];
                  st_d.sv[c][s] = fire;
                  for (int r = 0; r < 2; r++) begin
                     w = st_q.taps[c][r][s];
                     for (int k = 54; k > 0; k--) begin
                        if (k < ntaps(s)) begin
                           w[k] = w[k - 1];
                        end
                     end
                     w[0] = x[r];
                     st_d.taps[c][r][s] = w;
                     if (fire) begin
                        t = mac(s, w) >>> nshift(s);
                        st_d.so[c][s][r] = sat(t);
                     end
                  end
               end
               v = st_q.sv[c][s];
               x = st_q.so[c][s];
            end
         end

         // 6 dB is a saturating doubling
         if (ctrl[`DDCHB_CTRL_GAIN_BIT]) begin
            for (int r = 0; r < 2; r++) begin
               x[r] = dbl(x[r]);
            end
         end

         st_d.ov[c] = v;
         if (v) begin
            if (ctrl[`DDCHB_CTRL_REAL_BIT]) begin
               st_d.od[c][0] = rot(st_q.c2r[c], x);
               st_d.od[c][1] = '0;
               st_d.c2r[c] = st_q.c2r[c] + 2'h1;
            end else begin
               st_d.od[c][0] = x[0];
               // quadrature ignore forces Q to zero at the output
               st_d.od[c][1] = st_q.regs[0][`DDCHB_MODE_QIGN_BIT] ? '0 : x[1];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // stall the bus while frozen so no write is lost;
   // reads also wait until their data has been loaded
   assign pready = ce && (pwrite || st_q.rd_ok);
   assign pslverr = psel && penable && bus_slot == `DDCHB_SLOT_NONE;
   assign prdata = st_q.prdata;
   assign out0_valid = st_q.ov[0];
   assign out0_i = st_q.od[0][0];
   assign out0_q = st_q.od[0][1];
   assign out1_valid = st_q.ov[1];
   assign out1_i = st_q.od[1][0];
   assign out1_q = st_q.od[1][1];

endmodule
`default_nettype wire

// ### ddchb_back_end_checker.sv
// ddchb_back_end_checker.sv: port-level assertions for the half-band back end.
// assumes: bound onto ddchb_back_end; one pclk domain, presetn async low.
`timescale 1ns/10ps
`default_nettype none
module ddchb_back_end_checker (
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // channel outputs
   input wire logic out0_valid,
   input wire logic [15:0] out0_i,
   input wire logic [15:0] out0_q,
   input wire logic out1_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadows built from bus traffic, not from internals
   logic [7:0] mode_q, ctrl_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 8'h00;
         ctrl_q <= 8'h00;
      end else if (psel && penable && pwrite && ce) begin
         if (paddr == 12'h800) mode_q <= pwdata[7:0];
         if (paddr == 12'hC40) ctrl_q <= pwdata[7:0];
      end
   end
   sequence s_unal;
      psel && !penable && paddr[1:0] != 2'h0 ##1 psel && penable;
   endsequence
   property p_unal; s_unal |-> pslverr; endproperty
   property p_ready; !ce |-> !pready; endproperty
   property p_wready; psel && penable && pwrite |-> pready == ce; endproperty
   property p_err; pslverr |-> psel && penable; endproperty
   property p_hi; prdata[31:8] == 24'h000000; endproperty
   property p_hold; !out0_valid |-> $stable(out0_i) && $stable(out0_q); endproperty
   property p_freeze; !ce |=> $stable(out0_valid) && $stable(out0_i); endproperty
   property p_dec; !ctrl_q[3] && out0_valid && ce |=> !out0_valid; endproperty
   property p_real; ctrl_q[3] && out0_valid |-> out0_q == 16'h0000; endproperty
   property p_qign; mode_q[5] && out0_valid |-> out0_q == 16'h0000; endproperty
   property p_ch1; mode_q[1:0] != 2'h2 |-> !out1_valid; endproperty
   a_unal: assert property (p_unal) else $error("no error on unaligned access");
   a_ready: assert property (p_ready) else $error("pready high while frozen");
   a_wready: assert property (p_wready) else $error("write access not answered with ce");
   a_err: assert property (p_err) else $error("error outside access phase");
   a_hi: assert property (p_hi) else $error("upper read bits set");
   a_hold: assert property (p_hold) else $error("output moved without valid");
   a_freeze: assert property (p_freeze) else $error("state moved with ce low");
   a_dec: assert property (p_dec) else $error("final stage did not decimate");
   a_real: assert property (p_real) else $error("quadrature kept in real mode");
   a_qign: assert property (p_qign) else $error("quadrature kept when ignored");
   a_ch1: assert property (p_ch1) else $error("channel 1 active when off");
endmodule
bind ddchb_back_end ddchb_back_end_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .out0_valid(out0_valid),
   .out0_i(out0_i), .out0_q(out0_q), .out1_valid(out1_valid));
`default_nettype wire

// ### ddchb_adc_model.sv
// ddchb_adc_model.sv: converter-core stand-in feeding random samples.
// assumes: en from the bench; shares pclk with the block.
`timescale 1ns/10ps
`default_nettype none
module ddchb_adc_model (
   // clock and enable
   input wire logic pclk,
   input wire logic en,
   // sample stream
   output logic in_valid,
   output logic [15:0] adc_a,
   output logic [15:0] adc_b
);
   // data churns between samples too; gaps rare so most land back to back
   always @(posedge pclk) begin
      in_valid <= en && ($urandom_range(3) != 0);
      adc_a <= ($urandom_range(7) == 0) ? 16'h8000 : 16'($urandom);
      adc_b <= ($urandom_range(7) == 0) ? 16'h7FFF : 16'($urandom);
   end
endmodule
`default_nettype wire

// ### ddchb_back_end_tb.sv
// ddchb_back_end_tb.sv: self-checking bench, apb master plus reference filter.
// assumes: ddchb_adc_model feeds samples; 200 MHz pclk.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module ddchb_back_end_tb;
   logic pclk, presetn, ce, psel, penable, pwrite, en, in_valid, pready, pslverr, er;
   logic out0_valid, out1_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adc_a, adc_b, out0_i, out0_q, out1_i, out1_q;
   logic [7:0] ctl [2], sel [2], mode;
   logic [15:0] ei [2][$], eq [2][$];
   int err_count, comparisons, cycles, n_in, outs [2], cf [55];
   longint h [2][55];
   ddchb_back_end u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .adc_a(adc_a), .adc_b(adc_b),
      .out0_valid(out0_valid), .out0_i(out0_i), .out0_q(out0_q), .out1_valid(out1_valid),
      .out1_i(out1_i), .out1_q(out1_q));
   ddchb_adc_model u_src (.pclk(pclk), .en(en), .in_valid(in_valid), .adc_a(adc_a),
      .adc_b(adc_b));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [15:0] sat(longint v);
      return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : v[15:0];
   endfunction
   function automatic logic [15:0] gn(longint v, logic g);
      longint t = $signed(sat(v));
      return sat(g ? 2 * t : t);
   endfunction
   function automatic longint fir(int s);
      longint acc = 0;
      for (int k = 0; k < 55; k++) acc += cf[k] * h[s][k];
      return acc >>> 20;
   endfunction
   // fs/4 real output: I, -Q, -I, Q by output count
   function automatic logic [15:0] rot(logic [15:0] i, logic [15:0] q, int p);
      return p == 0 ? i : p == 2 ? sat(-longint'($signed(i))) :
         p == 1 ? sat(-longint'($signed(q))) : q;
   endfunction
   function automatic logic ena(int c);
      return c ? mode[1:0] == 2'h2 : mode[1:0] != 2'h0;
   endfunction
   function automatic int dv(int c);
      return (ctl[c][1:0] == 2'h3 ? 1 : ctl[c][1:0] == 2'h0 ? 2 : 4) * (ctl[c][3] ? 1 : 2);
   endfunction
   task automatic end_of_test();
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one idle cycle after each transfer so no strobe is driven twice at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic do_reset(input int n);
      presetn <= 1'b0;
      repeat (n) @(posedge pclk);
      presetn <= 1'b1;
      n_in = 0;
      outs = '{0, 0};
      h = '{default: 0};
      for (int c = 0; c < 2; c++) ei[c].delete();
      for (int c = 0; c < 2; c++) eq[c].delete();
   endtask
   task automatic ochk(int c, logic [15:0] i, logic [15:0] q);
      logic [15:0] xi, xq;
      outs[c]++;
      if (ei[c].size() > 0) begin
         xi = ei[c].pop_front();
         xq = eq[c].pop_front();
         `CHK(i, xi)
         `CHK(q, xq)
      end
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 10000) begin
         err_count++;
         end_of_test();
      end
   end
   always @(posedge pclk) begin
      logic [15:0] fi, fq;
      if (presetn && ce && in_valid === 1'b1) begin
         n_in++;
         for (int k = 54; k > 0; k--) h[0][k] = h[0][k-1];
         for (int k = 54; k > 0; k--) h[1][k] = h[1][k-1];
         h[0][0] = $signed(adc_a);
         h[1][0] = $signed(adc_b);
         for (int c = 0; c < 2; c++)
            if (ena(c) && ctl[c][1:0] == 2'h3 && (ctl[c][3] || n_in % 2 == 0)) begin
               fi = gn(fir(sel[c][0]), ctl[c][6]);
               fq = gn(fir(sel[c][2]), ctl[c][6]);
               ei[c].push_back(rot(fi, fq, ctl[c][3] ? (n_in - 1) % 4 : 0));
               eq[c].push_back((mode[5] || ctl[c][3]) ? 16'h0000 : fq);
            end
      end
      if (presetn && ce && out0_valid === 1'b1) ochk(0, out0_i, out0_q);
      if (presetn && ce && out1_valid === 1'b1) ochk(1, out1_i, out1_q);
   end
   initial begin
      logic [9:0] ix [14] = '{10'h200, 10'h201, 10'h310, 10'h311, 10'h314, 10'h315, 10'h320,
         10'h321, 10'h330, 10'h331, 10'h334, 10'h335, 10'h340, 10'h341};
      // mode, ctrl0, isel0, ctrl1, isel1
      logic [39:0] cfg [8] = '{40'h0183040000, 40'h01C3000000, 40'h028305C304,
         40'h2283048305, 40'h0280048004, 40'h018B040000, 40'h0181040000,
         40'h2249004905};
      int odd [14] = '{-24, 102, -302, 730, -1544, 2964, -5284, 8903, -14383, 22640,
         -35476, 57468, -105442, 331792};
      logic [7:0] d;
      {presetn, psel, penable, pwrite, en, paddr, pwdata} = '0;
      ce = 1'b1;
      void'($urandom(97567));
      for (int j = 0; j < 14; j++) cf[2*j] = odd[j];
      for (int j = 0; j < 14; j++) cf[54-2*j] = odd[j];
      cf[27] = 524288;
      do_reset(10);
      apb(1'b1, 12'h808, 32'h000000FF);
      apb(1'b0, 12'h808, 32'h0);
      `CHK(rd, 32'h00000000)
      foreach (ix[k]) begin
         d = 8'($urandom);
         apb(1'b0, {ix[k], 2'b00}, 32'h0);
         `CHK(rd, 32'h00000000)
         apb(1'b1, {ix[k], 2'b00}, {24'h0, d});
         apb(1'b0, {ix[k], 2'b00}, 32'h0);
         `CHK(rd, {24'h0, d})
      end
      apb(1'b0, 12'h80C, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, 12'hC41, 32'h0);
      `CHK(er, 1'b1)
      foreach (cfg[k]) begin
         {mode, ctl[0], sel[0], ctl[1], sel[1]} = cfg[k];
         do_reset(2);
         apb(1'b1, 12'hC40, ctl[0]);
         apb(1'b1, 12'hC44, sel[0]);
         apb(1'b1, 12'hCC0, ctl[1]);
         apb(1'b1, 12'hCC4, sel[1]);
         apb(1'b1, 12'h804, (mode[1:0] == 2'h1) ? 32'h01 : 32'h02);
         apb(1'b1, 12'h800, mode);
         en <= 1'b1;
         repeat (240) begin
            @(posedge pclk);
            ce <= ($urandom_range(7) != 0);
         end
         en <= 1'b0;
         ce <= 1'b1;
         repeat (40) @(posedge pclk);
         for (int c = 0; c < 2; c++)
            `CHK(outs[c], ena(c) ? n_in / dv(c) : 0)
      end
      end_of_test();
   end
endmodule
`default_nettype wire
